/* File: rtl/icr_map.svh */
// icr_map.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files and the interface
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH
`define ICR_CLK_MHZ 40
`define ICR_CAL_TIME_NS 3500
// least time rounds up
`define ICR_CAL_CYC ((`ICR_CAL_TIME_NS * `ICR_CLK_MHZ + 999) / 1000)
`define ICR_ROWS 1024
`define ICR_COLS 1280
`define ICR_PIX_W 10
`define ICR_KNEE_W 3
`define ICR_GAIN_W 4
`define ICR_OFFS_W 7
`define ICR_KNEE_RST 3'h0
`define ICR_GAIN_RST 4'h0
`define ICR_OFFS_RST 7'h40
// configuration word field positions
`define ICR_CFG_GLOBAL 0
`define ICR_CFG_MULTI 1
`define ICR_CFG_XSUB 2
`define ICR_CFG_EXTKNEE 3
`define ICR_CFG_COLOUR 4
`define ICR_CFG_KNEE_LSB 8
`define ICR_CFG_GAIN_LSB 11
`define ICR_CFG_OFFS_LSB 16
`define ICR_CFG_W 23
// controller register offsets
`define ICR_REG_CTRL 8'h00
`define ICR_REG_CFG 8'h04
`define ICR_REG_INT 8'h08
`define ICR_REG_ROWS 8'h0c
`define ICR_REG_STAT 8'h10
`define ICR_REG_PIXCNT 8'h14
`define ICR_REG_LAST 8'h18
`endif

/* File: rtl/icr_pkg.sv */
// icr_pkg.sv: types shared by both ends of the image core readout link
// assumes icr_map.svh for all numbers
`include "icr_map.svh"
package icr_pkg;
  // bayer colour tag carried beside each pixel
  typedef enum logic [1:0] {
    ICR_MONO = 2'h0,
    ICR_GREEN_ON_BLUE_ROW = 2'h1,
    ICR_BLUE = 2'h2,
    ICR_RED = 2'h3
  } icr_colour_t;
  // green_on_red_row shares the code space via a separate flag bit
  typedef enum logic [2:0] {
    ICR_IDLE = 3'h0,
    ICR_CAL = 3'h1,
    ICR_STREAM = 3'h3,
    ICR_ROWEND = 3'h2
  } icr_row_state_t;
endpackage

/* File: rtl/icr_link_if.sv */
// icr_link_if.sv: wires between camera controller and image core
// assumes both ends share clk_sys (the pixel_rate_clock)
`timescale 1ns/1ps
`include "icr_map.svh"
interface icr_link_if;
  logic int_start; // integration start pulse
  logic int_stop; // integration stop pulse
  logic row_load; // row pointer load
  logic row_clock; // row clock pulse
  logic frame_sync;
  logic line_sync;
  logic [`ICR_CFG_W-1:0] seq_cfg; // sequencer configuration word
  logic pix_valid;
  logic [`ICR_PIX_W-1:0] analog_pixel_output; // digitised pixel stream
  logic green_on_red_row; // pixel is green on a green-red row
  logic [1:0] pix_colour;
  logic row_done;
  modport core (input int_start, int_stop, row_load, row_clock,
    frame_sync, line_sync, seq_cfg, output pix_valid,
    analog_pixel_output, green_on_red_row, pix_colour, row_done);
  modport ctrl (output int_start, int_stop, row_load, row_clock,
    frame_sync, line_sync, seq_cfg, input pix_valid,
    analog_pixel_output, green_on_red_row, pix_colour, row_done);
endinterface

/* File: rtl/icr_core.sv */
// icr_core.sv: image core end; row pointers, integration sequencer,
// row calibration and pixel stream toward the converter
// assumes link inputs are driven from clk_sys by the controller
//
// Overview of operation
// - left pointer selects only the readout row
// - right pointer selects reset rows independently
// - multi-slope global mode resets whole array
// - rolling mode: right pointer resets one row
// - sequencer derives reset, sample, hold from pulses
// - controller makes integration and sync timing
// - readout starts with load plus row clock
// - calibrate amplifiers in blanking, about 3.5 us
// - pixels go out only after calibration
// - one pixel per system clock
// - system clock at most 40 MHz
// - global mode: readout ends before integration
// - sample switch global, or always closed
// - knee level from main supply, three bits
// - external knee supply disconnects generator
// - pixel (0,0) is green on green-blue row
// - two greens are told apart
// - converter sees only routed pixel signal
// - two columns per step, half rate, merged
// - one loaded at window start, then shift
// - pointer steps one, or two when subsampled
// - gain 4-bit exponential, offset 7-bit linear
`timescale 1ns/1ps
`include "icr_map.svh"
module icr_core #(
  parameter int ROWS = `ICR_ROWS,
  parameter int COLS = `ICR_COLS,
  parameter int CAL_CYC = `ICR_CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  icr_link_if.core lnk,
  input wire logic [`ICR_PIX_W-1:0] adc_pixel_in, // externally routed
  output logic [$clog2(ROWS)-1:0] read_row,
  output logic [$clog2(ROWS)-1:0] reset_row,
  output logic row_reset_en,
  output logic array_reset_all,
  output logic pixel_sample_switch,
  output logic pixel_hold,
  output logic [`ICR_KNEE_W-1:0] reset_knee_level_bits,
  output logic external_knee_supply_select,
  output logic [`ICR_GAIN_W-1:0] amp_gain_code,
  output logic [`ICR_OFFS_W-1:0] amp_offset_code,
  output logic cal_active
);
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(COLS);
  localparam int KW = $clog2(CAL_CYC + 1);
  logic [`ICR_CFG_W-1:0] cfg;
  logic global_mode, multi_slope, xsub, colour;
  icr_pkg::icr_row_state_t st_q;
  logic [KW-1:0] cal_cnt_q;
  logic [CW-1:0] col_q; // column of pair currently addressed
  logic half_q; // even/odd bus phase inside a column pair
  logic integ_q;
  logic [RW-1:0] next_read_q;
  logic [2:0] pix_tag;
  logic [CW:0] col_next;

  assign cfg = lnk.seq_cfg;
  assign global_mode = cfg[`ICR_CFG_GLOBAL];
  assign multi_slope = cfg[`ICR_CFG_MULTI];
  assign xsub = cfg[`ICR_CFG_XSUB];
  assign colour = cfg[`ICR_CFG_COLOUR];
  // colour tag of the pixel leaving this cycle
  assign pix_tag = bayer(read_row[0], half_q);
  // pair pointer after one step; the spare bit keeps the row-end compare against COLS from wrapping
  assign col_next = {1'b0, col_q} + (xsub ? (CW+1)'(4) : (CW+1)'(2));

  // bayer tag: row parity then column parity; origin is green/blue row
  function automatic logic [2:0] bayer(input logic r0, input logic c0);
    if (!r0) begin
      bayer = c0 ? {1'b0, 2'h2} : {1'b0, 2'h1};
    end else begin
      bayer = c0 ? {1'b1, 2'h1} : {1'b0, 2'h3};
    end
  endfunction

  // configuration fields drive analog settings straight through flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reset_knee_level_bits <= `ICR_KNEE_RST;
      external_knee_supply_select <= 1'b0;
      amp_gain_code <= `ICR_GAIN_RST;
      amp_offset_code <= `ICR_OFFS_RST;
    end else if (clk_en) begin
      reset_knee_level_bits <=
        cfg[`ICR_CFG_KNEE_LSB +: `ICR_KNEE_W];
      external_knee_supply_select <= cfg[`ICR_CFG_EXTKNEE];
      amp_gain_code <= cfg[`ICR_CFG_GAIN_LSB +: `ICR_GAIN_W];
      amp_offset_code <= cfg[`ICR_CFG_OFFS_LSB +: `ICR_OFFS_W];
    end
  end

  // integration sequencer: array reset at start, sample/hold at stop in global mode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      integ_q <= 1'b0;
      array_reset_all <= 1'b0;
      pixel_sample_switch <= 1'b1;
      pixel_hold <= 1'b0;
    end else if (clk_en) begin
      if (lnk.int_start) begin
        integ_q <= 1'b1;
      end else if (lnk.int_stop) begin
        integ_q <= 1'b0;
      end
      // whole array reset only in global mode, pulsed by start
      array_reset_all <= global_mode && lnk.int_start;
      if (global_mode) begin
        // one shared sample pulse closes all pixels at stop
        pixel_sample_switch <= lnk.int_stop;
        pixel_hold <= integ_q && lnk.int_stop;
      end else begin
        pixel_sample_switch <= 1'b1;
        pixel_hold <= 1'b0;
      end
    end
  end

  // rolling reset pointer walks on row clocks, apart from readout
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reset_row <= '0;
      row_reset_en <= 1'b0;
    end else if (clk_en) begin
      row_reset_en <= 1'b0;
      if (!global_mode && lnk.int_start) begin
        reset_row <= '0;
        row_reset_en <= 1'b1;
      end else if (!global_mode && integ_q && lnk.row_clock) begin
        reset_row <= (reset_row == RW'(ROWS - 1)) ? '0 : reset_row + 1'b1;
        row_reset_en <= 1'b1;
      end
      // multi-slope global reset uses the array flag instead
      if (global_mode && multi_slope) begin
        row_reset_en <= 1'b0;
      end
    end
  end

  // read pointer: load with row clock, else advance each row clock
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      read_row <= '0;
      next_read_q <= '0;
    end else if (clk_en && lnk.row_clock) begin
      if (lnk.row_load) begin
        read_row <= '0;
        next_read_q <= RW'(1);
      end else begin
        read_row <= next_read_q;
        next_read_q <= (next_read_q == RW'(ROWS - 1)) ? '0 :
          next_read_q + 1'b1;
      end
    end
  end

  // row sequence: calibrate in blanking, then stream the row
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= icr_pkg::ICR_IDLE;
      cal_cnt_q <= '0;
      col_q <= '0;
      half_q <= 1'b0;
      cal_active <= 1'b0;
    end else if (clk_en) begin
      unique case (st_q)
        icr_pkg::ICR_IDLE: begin
          if (lnk.row_clock) begin
            st_q <= icr_pkg::ICR_CAL;
            cal_cnt_q <= KW'(CAL_CYC - 1);
            cal_active <= 1'b1;
          end
        end
        icr_pkg::ICR_CAL: begin
          if (cal_cnt_q == '0) begin
            st_q <= icr_pkg::ICR_STREAM;
            cal_active <= 1'b0;
            col_q <= '0; // window start
            half_q <= 1'b0;
          end else begin
            cal_cnt_q <= cal_cnt_q - 1'b1;
          end
        end
        icr_pkg::ICR_STREAM: begin
          half_q <= ~half_q; // bus a then bus b
          if (half_q) begin
            // pair pointer steps at half rate, skipping a pair if sub
            if (col_next >= (CW+1)'(COLS)) begin
              st_q <= icr_pkg::ICR_ROWEND;
            end else begin
              col_q <= col_next[CW-1:0];
            end
          end
        end
        icr_pkg::ICR_ROWEND: begin
          st_q <= icr_pkg::ICR_IDLE;
        end
      endcase
    end
  end

  // merged stream: one pixel per clock with colour tag
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lnk.pix_valid <= 1'b0;
      lnk.analog_pixel_output <= '0;
      lnk.green_on_red_row <= 1'b0;
      lnk.pix_colour <= 2'h0;
      lnk.row_done <= 1'b0;
    end else if (clk_en) begin
      lnk.pix_valid <= (st_q == icr_pkg::ICR_STREAM);
      lnk.analog_pixel_output <= adc_pixel_in;
      lnk.green_on_red_row <= colour && pix_tag[2];
      lnk.pix_colour <= colour ? pix_tag[1:0] : 2'h0;
      lnk.row_done <= (st_q == icr_pkg::ICR_ROWEND);
    end
  end
endmodule // icr_core

/* File: rtl/icr_ctrl.sv */
// icr_ctrl.sv: camera controller end; makes integration and row timing,
// captures pixels; software port: addr, wdata, wr, rd, rdata next cycle
// assumes same clk_sys as the core
`timescale 1ns/1ps
`include "icr_map.svh"
module icr_ctrl #(
  parameter int ROWS = `ICR_ROWS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  icr_link_if.ctrl lnk,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [`ICR_PIX_W-1:0] cap_pixel,
  output logic cap_valid
);
  logic [`ICR_CFG_W-1:0] cfg_q;
  logic [15:0] int_len_q, int_cnt_q, rows_q, row_cnt_q;
  logic busy_q, integ_q, reading_q, first_q, row_wait_q;
  logic [31:0] pix_cnt_q;
  logic [`ICR_PIX_W-1:0] last_q;

  // register writes; a write of ctrl bit 0 starts one frame
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q <= '0;
      int_len_q <= 16'h0010;
      rows_q <= 16'(ROWS);
    end else if (clk_en && wr) begin
      if (addr == `ICR_REG_CFG) cfg_q <= wdata[`ICR_CFG_W-1:0];
      if (addr == `ICR_REG_INT) int_len_q <= wdata[15:0];
      if (addr == `ICR_REG_ROWS) rows_q <= wdata[15:0];
    end
  end

  // frame sequence: integrate, then read rows (global: no overlap)
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      integ_q <= 1'b0;
      reading_q <= 1'b0;
      first_q <= 1'b0;
      row_wait_q <= 1'b0;
      int_cnt_q <= '0;
      row_cnt_q <= '0;
      lnk.int_start <= 1'b0;
      lnk.int_stop <= 1'b0;
      lnk.row_load <= 1'b0;
      lnk.row_clock <= 1'b0;
      lnk.frame_sync <= 1'b0;
      lnk.line_sync <= 1'b0;
    end else if (clk_en) begin
      lnk.int_start <= 1'b0;
      lnk.int_stop <= 1'b0;
      lnk.row_load <= 1'b0;
      lnk.row_clock <= 1'b0;
      lnk.frame_sync <= 1'b0;
      lnk.line_sync <= 1'b0;
      if (!busy_q && wr && addr == `ICR_REG_CTRL && wdata[0]) begin
        busy_q <= 1'b1; // next frame only after readout ends
        integ_q <= 1'b1;
        int_cnt_q <= int_len_q;
        lnk.int_start <= 1'b1;
        lnk.frame_sync <= 1'b1;
      end else if (integ_q) begin
        if (int_cnt_q == '0) begin
          integ_q <= 1'b0;
          lnk.int_stop <= 1'b1;
          reading_q <= 1'b1;
          first_q <= 1'b1;
          row_cnt_q <= rows_q;
        end else begin
          int_cnt_q <= int_cnt_q - 1'b1;
        end
      end else if (reading_q && !row_wait_q) begin
        if (row_cnt_q == '0) begin
          reading_q <= 1'b0;
          busy_q <= 1'b0;
        end else begin
          lnk.row_clock <= 1'b1;
          lnk.row_load <= first_q;
          lnk.line_sync <= 1'b1;
          first_q <= 1'b0;
          row_wait_q <= 1'b1;
          row_cnt_q <= row_cnt_q - 1'b1;
        end
      end else if (row_wait_q && lnk.row_done) begin
        row_wait_q <= 1'b0;
      end
    end
  end

  // capture only valid stream pixels, never blanking
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cap_pixel <= '0;
      cap_valid <= 1'b0;
      pix_cnt_q <= '0;
      last_q <= '0;
    end else if (clk_en) begin
      cap_valid <= lnk.pix_valid;
      if (lnk.pix_valid) begin
        cap_pixel <= lnk.analog_pixel_output;
        last_q <= lnk.analog_pixel_output;
        pix_cnt_q <= pix_cnt_q + 32'h1;
      end
    end
  end

  // read data valid the cycle after rd, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          `ICR_REG_CFG: rdata <= 32'(cfg_q);
          `ICR_REG_INT: rdata <= {16'h0, int_len_q};
          `ICR_REG_ROWS: rdata <= {16'h0, rows_q};
          `ICR_REG_STAT: rdata <= {29'h0, reading_q, integ_q, busy_q};
          `ICR_REG_PIXCNT: rdata <= pix_cnt_q;
          `ICR_REG_LAST: rdata <= 32'(last_q);
          default: rdata <= '0;
        endcase
      end
    end
  end

  assign lnk.seq_cfg = cfg_q;
endmodule // icr_ctrl

/* File: tb/icr_link_props.sv */
// icr_link_props.sv: assertions on the link between controller and core
// assumes one clk_sys domain; link signals arrive as plain inputs
`timescale 1ns/1ps
`include "icr_map.svh"
module icr_link_props #(
  parameter int COLS = `ICR_COLS,
  parameter int CAL_CYC = `ICR_CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic int_start,
  input wire logic row_load,
  input wire logic row_clock,
  input wire logic frame_sync,
  input wire logic [`ICR_CFG_W-1:0] seq_cfg,
  input wire logic pix_valid,
  input wire logic row_done
);
  logic [15:0] since_q;
  logic [15:0] run_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // cycles since last row clock; saturates so long idle time never wraps
  always_ff @(posedge clk_sys) begin
    if (!resetn) since_q <= 16'hffff;
    else if (row_clock) since_q <= 16'h0001;
    else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
  end
  // length of the pixel run under way
  always_ff @(posedge clk_sys) begin
    if (!resetn) run_q <= 16'h0000;
    else if (pix_valid) run_q <= run_q + 16'h0001;
    else run_q <= 16'h0000;
  end
  // state change and output flop add two cycles to the calibration count
  a_cal_before_pix: assert property (
    $rose(pix_valid) |-> since_q == CAL_CYC + 2)
    else $error("pixel run did not start after calibration time");
  a_no_pix_blank: assert property (
    pix_valid |-> since_q > CAL_CYC)
    else $error("pixel valid during row blanking");
  a_row_length: assert property (
    $fell(pix_valid) |->
      run_q == (seq_cfg[`ICR_CFG_XSUB] ? COLS / 2 : COLS))
    else $error("pixel run length wrong");
  a_done_after_row: assert property (
    $fell(pix_valid) |-> ##[0:2] row_done)
    else $error("row done missing after pixel run");
  a_done_pulse: assert property (
    row_done |=> !row_done)
    else $error("row done longer than one cycle");
  a_load_with_clock: assert property (
    row_load |-> row_clock)
    else $error("row load without row clock");
  a_load_single: assert property (
    row_load |=> !row_load)
    else $error("row load longer than one row clock");
  a_sync_on_start: assert property (
    int_start |-> frame_sync)
    else $error("integration start without frame sync");
  a_start_pulse: assert property (
    int_start |=> !int_start)
    else $error("integration start longer than one cycle");
  a_no_overlap: assert property (
    int_start && seq_cfg[`ICR_CFG_GLOBAL] |-> !pix_valid)
    else $error("global integration overlaps readout");
  c_row_load: cover property (row_load);
  c_sub_row: cover property ($fell(pix_valid) && seq_cfg[`ICR_CFG_XSUB]);
  c_full_row: cover property ($fell(pix_valid) && !seq_cfg[`ICR_CFG_XSUB]);
endmodule // icr_link_props

/* File: tb/image_core_readout_control_bench.sv */
// image_core_readout_control_bench.sv: controller and core back to back
// assumes the map header, link interface and both ends compile first
`timescale 1ns/1ps
`include "icr_map.svh"
module image_core_readout_control_bench;
  localparam int ROWS = 4;
  localparam int COLS = 8;
  localparam int CAL = 4;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [`ICR_PIX_W-1:0] adc_pixel_in = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  logic [31:0] rdata;
  logic [31:0] cfg;
  logic [`ICR_PIX_W-1:0] cap_pixel;
  logic cap_valid;
  logic [1:0] read_row;
  logic [1:0] reset_row;
  logic row_reset_en, array_reset_all, sw, hold, ext, cal;
  logic [2:0] knee;
  logic [3:0] gain;
  logic [6:0] offs;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_rdone, n_pix, n_start, n_cal, n_swlo, t_start, gap;
  logic arr_seen, rrst_seen, hold_seen, got_col;
  logic [1:0] first_col;
  logic [2:0] tag_seen;
  logic col_on = 1'b0;
  logic [`ICR_PIX_W-1:0] adc_prev = '0;
  logic [`ICR_PIX_W-1:0] pix_q[$];
  icr_link_if lnk ();
  icr_core #(.ROWS(ROWS), .COLS(COLS), .CAL_CYC(CAL)) i_icr_core (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .lnk(lnk.core),
    .adc_pixel_in(adc_pixel_in), .read_row(read_row),
    .reset_row(reset_row), .row_reset_en(row_reset_en),
    .array_reset_all(array_reset_all), .pixel_sample_switch(sw),
    .pixel_hold(hold), .reset_knee_level_bits(knee),
    .external_knee_supply_select(ext), .amp_gain_code(gain),
    .amp_offset_code(offs), .cal_active(cal));
  icr_ctrl #(.ROWS(ROWS)) i_icr_ctrl (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .lnk(lnk.ctrl),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cap_pixel(cap_pixel), .cap_valid(cap_valid));
  icr_link_props #(.COLS(COLS), .CAL_CYC(CAL)) i_icr_link_props (
    .clk_sys(clk_sys), .resetn(resetn), .int_start(lnk.int_start),
    .row_load(lnk.row_load), .row_clock(lnk.row_clock),
    .frame_sync(lnk.frame_sync), .seq_cfg(lnk.seq_cfg),
    .pix_valid(lnk.pix_valid), .row_done(lnk.row_done));
  always #12.5 clk_sys = ~clk_sys;
  assign tag_seen = {lnk.green_on_red_row, lnk.pix_colour};
  // converter input changes every cycle so stale data never looks right;
  // a valid stream pixel carries the word the core took one edge earlier
  always @(posedge clk_sys) begin
    if (lnk.pix_valid) pix_q.push_back(adc_prev);
    adc_prev <= adc_pixel_in;
    adc_pixel_in <= `ICR_PIX_W'($urandom);
  end
  // each captured pixel must be the converter word of its stream slot
  always @(posedge clk_sys) begin
    if (cap_valid) check(cap_pixel, pix_q.pop_front());
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bayer tag from the rules: origin is green on a green-blue row
  function automatic logic [2:0] exp_tag(input logic r, input logic c,
      input logic on);
    if (!on) return 3'h0;
    if (!r) return c ? 3'h2 : 3'h1;
    return c ? 3'h5 : 3'h3;
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // the expected value is noted here and compared by the read watcher
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_p) check(rdata, exp_q.pop_front());
    rd_p <= rd;
  end
  // frame watcher; cleared on the falling edge to stay clear of races
  always @(posedge clk_sys) begin
    cyc++;
    if (lnk.pix_valid) begin
      check(tag_seen, exp_tag(n_rdone[0], n_pix[0], col_on));
    end
    if (lnk.row_done) n_rdone++;
    if (lnk.pix_valid) n_pix++;
    if (lnk.pix_valid && !got_col) first_col = lnk.pix_colour;
    if (lnk.pix_valid) got_col = 1'b1;
    if (cal) n_cal++;
    if (!sw) n_swlo++;
    if (array_reset_all) arr_seen = 1'b1;
    if (row_reset_en) rrst_seen = 1'b1;
    if (hold) hold_seen = 1'b1;
    if (lnk.int_stop) gap = cyc - t_start;
    if (lnk.int_start) n_start++;
    if (lnk.int_start) t_start = cyc;
    // two short frames need under two hundred cycles; far more means a hang
    if (cyc == 2000) n_mismatch++;
    if (cyc == 2000) close_out();
  end
  task automatic run_frame(input logic [31:0] c, input bit poke);
    wr_reg(`ICR_REG_CFG, c);
    wr_reg(`ICR_REG_INT, 32'h5);
    rd_reg(`ICR_REG_CFG, c & 32'h007fffff);
    @(negedge clk_sys);
    {n_rdone, n_pix, n_start, n_cal, n_swlo, gap} = '0;
    {arr_seen, rrst_seen, hold_seen, got_col} = '0;
    col_on = c[`ICR_CFG_COLOUR];
    wr_reg(`ICR_REG_CTRL, 32'h1);
    // a second start while busy must be ignored
    if (poke) wr_reg(`ICR_REG_CTRL, 32'h1);
    for (int i = 0; i < 4000 && n_rdone < ROWS; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(pix_q.size(), 0);
    check(n_rdone, ROWS);
    check(n_start, 1);
    check(gap, 6);
    check(n_cal, ROWS * CAL);
    check(first_col, {1'b0, c[`ICR_CFG_COLOUR]});
    check(knee, c[10:8]);
    check(ext, c[`ICR_CFG_EXTKNEE]);
    check(gain, c[14:11]);
    check(offs, c[22:16]);
    check(n_pix, ROWS * (c[`ICR_CFG_XSUB] ? COLS / 2 : COLS));
  endtask
  initial begin
    void'($urandom(78));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check(sw, 1'b1);
    check(offs, `ICR_OFFS_RST);
    check(gain, `ICR_GAIN_RST);
    check(knee, `ICR_KNEE_RST);
    check({read_row, reset_row, row_reset_en, array_reset_all, cal, ext}, 0);
    rd_reg(`ICR_REG_INT, 32'h10);
    rd_reg(`ICR_REG_ROWS, ROWS);
    rd_reg(8'h20, 32'h0);
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr_reg(`ICR_REG_INT, 32'h33);
    clk_en <= 1'b1;
    rd_reg(`ICR_REG_INT, 32'h10);
    // rolling, colour, random knee, gain and offset
    cfg = $urandom & 32'h007fff08;
    run_frame(cfg | 32'h10, 1'b0);
    check(n_swlo, 0);
    check(rrst_seen, 1'b1);
    // global multi-slope, column sub-sampling, start poked while busy
    cfg = $urandom & 32'h007fff08;
    run_frame(cfg | 32'h7, 1'b1);
    check(arr_seen, 1'b1);
    check(hold_seen, 1'b1);
    check(n_swlo != 0, 1'b1);
    repeat (4) @(posedge clk_sys);
    close_out();
  end
endmodule // image_core_readout_control_bench
